//--- include/tc_pkg.sv
/*
 Constants shared by the timer/counter with input capture and its bus master:
 register indices, field positions, reset values, mode codes and filter length.
 Assumes an 8-bit register bus with a 4-bit register index.
*/
// Behaviour
// - 16-bit counter seen as two byte locations
// - Low read loads temp; high location is temp
// - Low write loads all sixteen bits at once
// - Each tick clears, increments or decrements counter
// - Select zero stops counting; CPU access stays
// - CPU write beats count or clear
// - Mode bits split across control A and B
// - Wrap flag set per mode; interrupt source
// - Flag zero and top of the counter
// - Matching trigger edge copies counter to capture
// - Capture flag set in the copy cycle
// - Flag requests interrupt; cleared by ack/one
// - Capture read low first, high from temp
// - Capture writable only in capture-top modes
// - Comparator select switches trigger; clear flag after
// - Pin and comparator synchronised then edge detected
// - Sampled every clock; four cycles delay
// - Filter output changes after four equal samples
// - Filter adds four cycles, runs on clock
// - Capture input off in capture-top modes
// - Driving the pin by software also captures
// - New capture overwrites the old value
// - Duty measure: flip edge, then clear flag
package tc_pkg;
	// Register indices on the device bus
	localparam logic [3:0] CNT_LO = 4'h0;
	localparam logic [3:0] CNT_HI = 4'h1;
	localparam logic [3:0] CAP_LO = 4'h2;
	localparam logic [3:0] CAP_HI = 4'h3;
	localparam logic [3:0] CTRL_A = 4'h4;
	localparam logic [3:0] CTRL_B = 4'h5;
	localparam logic [3:0] FLAGS = 4'h6;
	localparam logic [3:0] MASK = 4'h7;
	localparam logic [3:0] CMP_CTRL = 4'h8;
	// Field positions
	localparam int A_WAVE_LSB = 0;
	localparam int B_CLK_LSB = 0;
	localparam int B_WAVE_LSB = 3;
	localparam int B_EDGE_BIT = 6;
	localparam int B_FILT_BIT = 7;
	localparam int F_WRAP_BIT = 0;
	localparam int F_CAP_BIT = 5;
	localparam int C_TRIG_BIT = 2;
	// Reset values
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [15:0] CNT_RST = 16'h0000;
	// Counter extremes and fixed tops
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] TOP_8 = 16'h00FF;
	localparam logic [15:0] TOP_9 = 16'h01FF;
	localparam logic [15:0] TOP_10 = 16'h03FF;
	// Clock select codes and prescaler taps
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam int PRE_W = 10;
	// Filter sample count
	localparam int FILT_LEN = 4;
	// Host register indices and command bits
	localparam logic [1:0] H_DATA = 2'h0;
	localparam logic [1:0] H_ADDR = 2'h1;
	localparam logic [1:0] H_CMD = 2'h2;
	localparam logic [1:0] H_STAT = 2'h3;
	localparam int CMD_GO_BIT = 0;
	localparam int CMD_RD_BIT = 1;
	localparam int CMD_WIDE_BIT = 2;
endpackage : tc_pkg

//--- include/tc_bus_if.sv
/*
 Register bus joining the timer/counter and its bus master.
 Assumes both ends share one clock; the master leads every access.
*/
`timescale 1ns/10ps
interface tc_bus_if;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic cap_irq;
	logic wrap_irq;
	logic cap_ack;
	logic wrap_ack;
	modport dev (input addr, input wdata, input wr, input rd, input cap_ack, input wrap_ack,
		output rdata, output cap_irq, output wrap_irq);
	modport cpu (output addr, output wdata, output wr, output rd, output cap_ack,
		output wrap_ack, input rdata, input cap_irq, input wrap_irq);
endinterface : tc_bus_if

//--- rtl/tc_capture_timer.sv
/*
 16-bit timer/counter with input capture, byte-wide register bus.
 Assumes pins arrive asynchronously and the bus master is on i_clk.
*/
`timescale 1ns/10ps
module tc_capture_timer (
	input wire logic i_clk, // System clock
	input wire logic i_reset_n, // Asynchronous reset, active low
	tc_bus_if.dev bus, // Register bus
	input wire logic i_capture_pin, // Capture trigger pin
	input wire logic i_comparator_out, // Analog comparator result
	input wire logic i_ext_tick_pin, // External count clock pin
	output logic o_at_zero_flag, // Counter at zero
	output logic o_at_top_flag // Counter at top
);
	// Top value per mode; capture-top modes use the capture register
	function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] cap);
		unique case (m)
			4'd1, 4'd5: top_of = tc_pkg::TOP_8;
			4'd2, 4'd6: top_of = tc_pkg::TOP_9;
			4'd3, 4'd7: top_of = tc_pkg::TOP_10;
			4'd8, 4'd10, 4'd12, 4'd14: top_of = cap;
			default: top_of = tc_pkg::CNT_MAX;
		endcase
	endfunction : top_of

	// Modes whose top is the capture register
	function automatic logic cap_is_top(input logic [3:0] m);
		cap_is_top = (m == 4'd8) || (m == 4'd10) || (m == 4'd12) || (m == 4'd14);
	endfunction : cap_is_top

	// Dual-slope modes count up then down
	function automatic logic dual_slope(input logic [3:0] m);
		dual_slope = (m >= 4'd1 && m <= 4'd3) || (m >= 4'd8 && m <= 4'd11);
	endfunction : dual_slope

	logic [7:0] ctrl_a_reg, ctrl_a_next, ctrl_b_reg, ctrl_b_next;
	logic [7:0] mask_reg, mask_next, cmp_reg, cmp_next, temp_reg, temp_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [15:0] cnt_reg, cnt_next, cap_reg, cap_next;
	logic down_reg, down_next, wrap_f_reg, wrap_f_next, cap_f_reg, cap_f_next;
	logic cap_irq_reg, cap_irq_next, wrap_irq_reg, wrap_irq_next;
	logic zero_reg, zero_next, top_reg, top_next;
	logic [2:0] pin_sync_reg, pin_sync_next, cmp_sync_reg, cmp_sync_next;
	logic [2:0] ext_sync_reg, ext_sync_next;
	logic pin_val_reg, pin_val_next, cmp_val_reg, cmp_val_next, ext_val_reg, ext_val_next;
	logic [tc_pkg::FILT_LEN-2:0] hist_reg, hist_next;
	logic [tc_pkg::FILT_LEN-1:0] window;
	logic filt_reg, filt_next, trig_prev_reg, trig_prev_next;
	logic [tc_pkg::PRE_W-1:0] pre_reg, pre_next;
	logic [3:0] mode;
	logic [15:0] top;
	logic tick, trig, cap_event, ext_rise, ext_fall, wrap_set;

	assign mode = {ctrl_b_reg[tc_pkg::B_WAVE_LSB +: 2], ctrl_a_reg[tc_pkg::A_WAVE_LSB +: 2]};
	assign top = top_of(mode, cap_reg);

	// Three-stage samplers; stages two and three must agree before a change counts
	always_comb begin
		pin_sync_next = {pin_sync_reg[1:0], i_capture_pin};
		cmp_sync_next = {cmp_sync_reg[1:0], i_comparator_out};
		ext_sync_next = {ext_sync_reg[1:0], i_ext_tick_pin};
		pin_val_next = (pin_sync_reg[1] == pin_sync_reg[2]) ? pin_sync_reg[2] : pin_val_reg;
		cmp_val_next = (cmp_sync_reg[1] == cmp_sync_reg[2]) ? cmp_sync_reg[2] : cmp_val_reg;
		ext_val_next = (ext_sync_reg[1] == ext_sync_reg[2]) ? ext_sync_reg[2] : ext_val_reg;
	end

	// External clock edges, detected on the sampled level
	assign ext_rise = ext_val_next & ~ext_val_reg;
	assign ext_fall = ~ext_val_next & ext_val_reg;

	// Free-running prescaler and tick selection
	always_comb begin
		pre_next = pre_reg + 1'b1;
		unique case (ctrl_b_reg[tc_pkg::B_CLK_LSB +: 3])
			tc_pkg::CS_STOP: tick = 1'b0;
			tc_pkg::CS_DIV1: tick = 1'b1;
			tc_pkg::CS_DIV8: tick = (pre_reg[2:0] == 3'h7);
			tc_pkg::CS_DIV64: tick = (pre_reg[5:0] == 6'h3F);
			tc_pkg::CS_DIV256: tick = (pre_reg[7:0] == 8'hFF);
			tc_pkg::CS_DIV1024: tick = (pre_reg == 10'h3FF);
			tc_pkg::CS_EXT_FALL: tick = ext_fall;
			default: tick = ext_rise;
		endcase
	end

	// Trigger source, noise filter and edge detector
	always_comb begin
		trig = cmp_reg[tc_pkg::C_TRIG_BIT] ? cmp_val_reg : pin_val_reg;
		window = {hist_reg, trig}; // Newest sample plus three stored: four cycles added
		hist_next = window[tc_pkg::FILT_LEN-2:0];
		filt_next = filt_reg;
		if (&window || ~|window) begin
			filt_next = trig;
		end
		trig_prev_next = ctrl_b_reg[tc_pkg::B_FILT_BIT] ? filt_reg : trig;
		cap_event = ~cap_is_top(mode) && (trig_prev_next != trig_prev_reg)
			&& (trig_prev_next == ctrl_b_reg[tc_pkg::B_EDGE_BIT]);
	end

	// Counter, capture, flags, temp byte and register bus
	always_comb begin
		ctrl_a_next = ctrl_a_reg;
		ctrl_b_next = ctrl_b_reg;
		mask_next = mask_reg;
		cmp_next = cmp_reg;
		temp_next = temp_reg;
		cnt_next = cnt_reg;
		cap_next = cap_reg;
		down_next = down_reg;
		wrap_f_next = wrap_f_reg;
		cap_f_next = cap_f_reg;
		wrap_set = 1'b0;
		rdata_next = tc_pkg::REG_RST;
		// Count sequence per mode
		if (tick) begin
			if (dual_slope(mode)) begin
				if (!down_reg && cnt_reg >= top) begin
					down_next = 1'b1;
					cnt_next = cnt_reg - 1'b1;
				end else if (down_reg && cnt_reg == 16'h0000) begin
					down_next = 1'b0;
					cnt_next = cnt_reg + 1'b1;
					wrap_set = 1'b1;
				end else begin
					cnt_next = down_reg ? cnt_reg - 1'b1 : cnt_reg + 1'b1;
				end
			end else begin
				down_next = 1'b0;
				if (cnt_reg == top) begin
					cnt_next = 16'h0000;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
				if (cnt_reg == tc_pkg::CNT_MAX || (cnt_reg == top && mode >= 4'd5)) begin
					wrap_set = 1'b1;
				end
			end
		end
		// Register reads; read data stand in the next cycle
		if (bus.rd) begin
			unique case (bus.addr)
				tc_pkg::CNT_LO: begin
					rdata_next = cnt_reg[7:0];
					temp_next = cnt_reg[15:8];
				end
				tc_pkg::CAP_LO: begin
					rdata_next = cap_reg[7:0];
					temp_next = cap_reg[15:8];
				end
				tc_pkg::CNT_HI, tc_pkg::CAP_HI: rdata_next = temp_reg;
				tc_pkg::CTRL_A: rdata_next = ctrl_a_reg;
				tc_pkg::CTRL_B: rdata_next = ctrl_b_reg;
				tc_pkg::FLAGS: rdata_next = 8'(cap_f_reg) << tc_pkg::F_CAP_BIT
					| 8'(wrap_f_reg) << tc_pkg::F_WRAP_BIT;
				tc_pkg::MASK: rdata_next = mask_reg;
				tc_pkg::CMP_CTRL: rdata_next = cmp_reg;
				default: rdata_next = tc_pkg::REG_RST;
			endcase
		end
		// Flag clears by write of one or interrupt ack
		if ((bus.wr && bus.addr == tc_pkg::FLAGS && bus.wdata[tc_pkg::F_CAP_BIT]) || bus.cap_ack) begin
			cap_f_next = 1'b0;
		end
		if ((bus.wr && bus.addr == tc_pkg::FLAGS && bus.wdata[tc_pkg::F_WRAP_BIT])
			|| bus.wrap_ack) begin
			wrap_f_next = 1'b0;
		end
		// Wrap set beats a clear in the same cycle, whatever the mode
		if (wrap_set) begin
			wrap_f_next = 1'b1;
		end
		// Register writes; counter write overrides counting
		if (bus.wr) begin
			unique case (bus.addr)
				tc_pkg::CNT_LO: cnt_next = {temp_reg, bus.wdata};
				tc_pkg::CNT_HI, tc_pkg::CAP_HI: temp_next = bus.wdata;
				tc_pkg::CAP_LO: begin
					if (cap_is_top(mode)) begin
						cap_next = {temp_reg, bus.wdata};
					end
				end
				tc_pkg::CTRL_A: ctrl_a_next = bus.wdata;
				tc_pkg::CTRL_B: ctrl_b_next = bus.wdata;
				tc_pkg::MASK: mask_next = bus.wdata;
				tc_pkg::CMP_CTRL: cmp_next = bus.wdata;
				default: ;
			endcase
		end
		// Capture stamp and flag in one cycle; set beats clear
		if (cap_event) begin
			cap_next = cnt_reg;
			cap_f_next = 1'b1;
		end
		cap_irq_next = cap_f_next & mask_next[tc_pkg::F_CAP_BIT];
		wrap_irq_next = wrap_f_next & mask_next[tc_pkg::F_WRAP_BIT];
		zero_next = (cnt_next == 16'h0000);
		top_next = (cnt_next == top_of(mode, cap_next));
	end

	// State registers
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_a_reg <= tc_pkg::REG_RST;
			ctrl_b_reg <= tc_pkg::REG_RST;
			mask_reg <= tc_pkg::REG_RST;
			cmp_reg <= tc_pkg::REG_RST;
			temp_reg <= tc_pkg::REG_RST;
			rdata_reg <= tc_pkg::REG_RST;
			cnt_reg <= tc_pkg::CNT_RST;
			cap_reg <= tc_pkg::CNT_RST;
			down_reg <= 1'b0;
			wrap_f_reg <= 1'b0;
			cap_f_reg <= 1'b0;
			cap_irq_reg <= 1'b0;
			wrap_irq_reg <= 1'b0;
			zero_reg <= 1'b1;
			top_reg <= 1'b0;
			pin_sync_reg <= 3'h0;
			cmp_sync_reg <= 3'h0;
			ext_sync_reg <= 3'h0;
			pin_val_reg <= 1'b0;
			cmp_val_reg <= 1'b0;
			ext_val_reg <= 1'b0;
			hist_reg <= '0;
			filt_reg <= 1'b0;
			trig_prev_reg <= 1'b0;
			pre_reg <= '0;
		end else begin
			ctrl_a_reg <= ctrl_a_next;
			ctrl_b_reg <= ctrl_b_next;
			mask_reg <= mask_next;
			cmp_reg <= cmp_next;
			temp_reg <= temp_next;
			rdata_reg <= rdata_next;
			cnt_reg <= cnt_next;
			cap_reg <= cap_next;
			down_reg <= down_next;
			wrap_f_reg <= wrap_f_next;
			cap_f_reg <= cap_f_next;
			cap_irq_reg <= cap_irq_next;
			wrap_irq_reg <= wrap_irq_next;
			zero_reg <= zero_next;
			top_reg <= top_next;
			pin_sync_reg <= pin_sync_next;
			cmp_sync_reg <= cmp_sync_next;
			ext_sync_reg <= ext_sync_next;
			pin_val_reg <= pin_val_next;
			cmp_val_reg <= cmp_val_next;
			ext_val_reg <= ext_val_next;
			hist_reg <= hist_next;
			filt_reg <= filt_next;
			trig_prev_reg <= trig_prev_next;
			pre_reg <= pre_next;
		end
	end

	// Outputs straight from flops
	assign bus.rdata = rdata_reg;
	assign bus.cap_irq = cap_irq_reg;
	assign bus.wrap_irq = wrap_irq_reg;
	assign o_at_zero_flag = zero_reg;
	assign o_at_top_flag = top_reg;
endmodule : tc_capture_timer

//--- rtl/tc_bus_master.sv
/*
 Bus master for the timer: runs byte and 16-bit accesses and acks interrupts.
 Assumes software drives the plain command port on i_clk.
*/
`timescale 1ns/10ps
module tc_bus_master (
	input wire logic i_clk, // System clock
	input wire logic i_reset_n, // Asynchronous reset, active low
	tc_bus_if.cpu bus, // Register bus to the timer
	input wire logic [1:0] i_addr, // Command register index
	input wire logic [15:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [15:0] o_rdata // Read data, one cycle after i_rd
);
	typedef enum logic [1:0] {S_IDLE, S_FIRST, S_SECOND, S_LAST} state_t;
	state_t state_reg, state_next;
	logic [15:0] data_reg, data_next, rdata_reg, rdata_next;
	logic [3:0] taddr_reg, taddr_next, baddr_reg, baddr_next;
	logic [2:0] cmd_reg, cmd_next;
	logic [7:0] bwdata_reg, bwdata_next;
	logic bwr_reg, bwr_next, brd_reg, brd_next, cack_reg, cack_next, wack_reg, wack_next;
	logic [1:0] irq_seen_reg, irq_seen_next;

	// Access sequencer: wide reads low then high, wide writes high then low
	always_comb begin
		state_next = state_reg;
		data_next = data_reg;
		taddr_next = taddr_reg;
		cmd_next = cmd_reg;
		baddr_next = baddr_reg;
		bwdata_next = bwdata_reg;
		bwr_next = 1'b0;
		brd_next = 1'b0;
		rdata_next = 16'h0000;
		irq_seen_next = irq_seen_reg | {bus.cap_irq, bus.wrap_irq};
		cack_next = bus.cap_irq & ~cack_reg;
		wack_next = bus.wrap_irq & ~wack_reg;
		if (i_rd) begin
			unique case (i_addr)
				tc_pkg::H_DATA: rdata_next = data_reg;
				tc_pkg::H_ADDR: rdata_next = {12'h000, taddr_reg};
				tc_pkg::H_CMD: rdata_next = {13'h0000, cmd_reg};
				tc_pkg::H_STAT: begin
					rdata_next = {13'h0000, irq_seen_reg, state_reg != S_IDLE};
					irq_seen_next = {bus.cap_irq, bus.wrap_irq};
				end
			endcase
		end
		unique case (state_reg)
			S_IDLE: begin
				if (i_wr) begin
					unique case (i_addr)
						tc_pkg::H_DATA: data_next = i_wdata;
						tc_pkg::H_ADDR: taddr_next = i_wdata[3:0];
						tc_pkg::H_CMD: cmd_next = i_wdata[2:0];
						default: ;
					endcase
				end
				if (i_wr && i_addr == tc_pkg::H_CMD && i_wdata[tc_pkg::CMD_GO_BIT]) begin
					state_next = S_FIRST;
					brd_next = i_wdata[tc_pkg::CMD_RD_BIT];
					bwr_next = ~i_wdata[tc_pkg::CMD_RD_BIT];
					if (i_wdata[tc_pkg::CMD_WIDE_BIT] && !i_wdata[tc_pkg::CMD_RD_BIT]) begin
						baddr_next = taddr_reg + 4'h1;
						bwdata_next = data_reg[15:8];
					end else begin
						baddr_next = taddr_reg;
						bwdata_next = data_reg[7:0];
					end
				end
			end
			S_FIRST: begin
				state_next = cmd_reg[tc_pkg::CMD_WIDE_BIT] ? S_SECOND : S_LAST;
				if (cmd_reg[tc_pkg::CMD_WIDE_BIT]) begin
					brd_next = cmd_reg[tc_pkg::CMD_RD_BIT];
					bwr_next = ~cmd_reg[tc_pkg::CMD_RD_BIT];
					baddr_next = cmd_reg[tc_pkg::CMD_RD_BIT] ? taddr_reg + 4'h1 : taddr_reg;
					bwdata_next = data_reg[7:0];
				end
			end
			S_SECOND: begin
				state_next = S_LAST;
				if (cmd_reg[tc_pkg::CMD_RD_BIT]) begin
					data_next = {8'h00, bus.rdata};
				end
			end
			S_LAST: begin
				state_next = S_IDLE;
				if (cmd_reg[tc_pkg::CMD_RD_BIT]) begin
					data_next = cmd_reg[tc_pkg::CMD_WIDE_BIT] ? {bus.rdata, data_reg[7:0]}
						: {8'h00, bus.rdata};
				end
			end
		endcase
	end

	// State registers
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= S_IDLE;
			data_reg <= 16'h0000;
			rdata_reg <= 16'h0000;
			taddr_reg <= 4'h0;
			baddr_reg <= 4'h0;
			cmd_reg <= 3'h0;
			bwdata_reg <= 8'h00;
			bwr_reg <= 1'b0;
			brd_reg <= 1'b0;
			cack_reg <= 1'b0;
			wack_reg <= 1'b0;
			irq_seen_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			data_reg <= data_next;
			rdata_reg <= rdata_next;
			taddr_reg <= taddr_next;
			baddr_reg <= baddr_next;
			cmd_reg <= cmd_next;
			bwdata_reg <= bwdata_next;
			bwr_reg <= bwr_next;
			brd_reg <= brd_next;
			cack_reg <= cack_next;
			wack_reg <= wack_next;
			irq_seen_reg <= irq_seen_next;
		end
	end

	// Outputs straight from flops
	assign bus.addr = baddr_reg;
	assign bus.wdata = bwdata_reg;
	assign bus.wr = bwr_reg;
	assign bus.rd = brd_reg;
	assign bus.cap_ack = cack_reg;
	assign bus.wrap_ack = wack_reg;
	assign o_rdata = rdata_reg;
endmodule : tc_bus_master

//--- sim/tc_assertions.sv
/*
 Checker for the timer register bus: read answers, strobes, acks, byte pairing.
 Assumes one clock and that tb instantiates it beside the bus interface.
*/
`timescale 1ns/10ps
module tc_assertions (
	input wire logic i_clk, // System clock
	input wire logic i_reset_n, // Reset, active low
	input wire logic [3:0] i_addr, // Register index
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	input wire logic [7:0] i_rdata, // Read data
	input wire logic i_cap_irq, // Capture request
	input wire logic i_wrap_irq, // Wrap request
	input wire logic i_cap_ack, // Capture ack
	input wire logic i_wrap_ack, // Wrap ack
	input wire logic i_at_zero_flag, // Counter at zero
	input wire logic i_at_top_flag // Counter at top
);
	// One clock domain for all checks
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	// Read data only in the answer cycle
	AST_RDATA_IDLE: assert property (!i_rd |=> i_rdata == 8'h00)
		else $error("read data outside answer cycle");
	AST_UNMAPPED: assert property (i_rd && i_addr > 4'h8 |=> i_rdata == 8'h00)
		else $error("unmapped index answered");
	AST_STROBES: assert property (!(i_wr && i_rd))
		else $error("read and write strobes together");
	// Acks follow requests and clear them
	AST_CAP_ACK_CAUSE: assert property (i_cap_ack |-> $past(i_cap_irq))
		else $error("capture ack without request");
	AST_CAP_ACK_CLEAR: assert property (i_cap_ack |-> ##[1:2] !i_cap_irq)
		else $error("capture request not cleared by ack");
	AST_WRAP_ACK_CAUSE: assert property (i_wrap_ack |-> $past(i_wrap_irq))
		else $error("wrap ack without request");
	AST_WRAP_ACK_CLEAR: assert property (i_wrap_ack |-> ##[1:2] !i_wrap_irq)
		else $error("wrap request not cleared by ack");
	// Byte order of sixteen-bit accesses
	AST_CNT_HI_RD: assert property (i_rd && i_addr == tc_pkg::CNT_HI |->
		$past(i_rd) && $past(i_addr) == tc_pkg::CNT_LO)
		else $error("counter high read not after low read");
	AST_CAP_HI_RD: assert property (i_rd && i_addr == tc_pkg::CAP_HI |->
		$past(i_rd) && $past(i_addr) == tc_pkg::CAP_LO)
		else $error("capture high read not after low read");
	AST_CNT_LO_WR: assert property (i_wr && i_addr == tc_pkg::CNT_LO |->
		$past(i_wr) && $past(i_addr) == tc_pkg::CNT_HI)
		else $error("counter low write not after high write");
	AST_CAP_LO_WR: assert property (i_wr && i_addr == tc_pkg::CAP_LO |->
		$past(i_wr) && $past(i_addr) == tc_pkg::CAP_HI)
		else $error("capture low write not after high write");
	AST_ZERO_TOP: assert property (!(i_at_zero_flag && i_at_top_flag))
		else $error("zero and top flags together");
endmodule : tc_assertions

//--- sim/tb.sv
/*
 Testbench: bus master and timer joined by the bus interface, driven from the host port.
 Assumes a 25 MHz clock and capture pins driven by the bench.
*/
`timescale 1ns/10ps
module tb;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [1:0] h_addr = 2'h0;
	logic [15:0] h_wdata = 16'h0000;
	logic h_wr = 1'b0;
	logic h_rd = 1'b0;
	logic [15:0] h_rdata;
	logic cap_pin = 1'b0;
	logic comp_out = 1'b0;
	logic ext_pin = 1'b0;
	logic zero_flag;
	logic top_flag;
	logic top_seen = 1'b0;
	logic [2:0] seen = 3'h0;
	logic [15:0] v;
	logic [15:0] c;
	int n0;
	int n1;
	int miscompares = 0;
	int checks = 0;

	tc_bus_if bus ();
	tc_capture_timer i_tc_capture_timer (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus),
		.i_capture_pin(cap_pin), .i_comparator_out(comp_out), .i_ext_tick_pin(ext_pin),
		.o_at_zero_flag(zero_flag), .o_at_top_flag(top_flag));
	tc_bus_master i_tc_bus_master (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus),
		.i_addr(h_addr), .i_wdata(h_wdata), .i_wr(h_wr), .i_rd(h_rd), .o_rdata(h_rdata));
	tc_assertions i_tc_assertions (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(bus.addr),
		.i_wr(bus.wr), .i_rd(bus.rd), .i_rdata(bus.rdata), .i_cap_irq(bus.cap_irq),
		.i_wrap_irq(bus.wrap_irq), .i_cap_ack(bus.cap_ack), .i_wrap_ack(bus.wrap_ack),
		.i_at_zero_flag(zero_flag), .i_at_top_flag(top_flag));

	// Clock and top flag monitor
	always #20 i_clk = ~i_clk;
	always @(posedge i_clk) if (top_flag === 1'b1) top_seen <= 1'b1;

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: saw %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic host_wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge i_clk);
		h_addr <= a;
		h_wdata <= d;
		h_wr <= 1'b1;
		@(posedge i_clk);
		h_wr <= 1'b0;
	endtask : host_wr

	task automatic host_rd(input logic [1:0] a, output logic [15:0] d);
		@(posedge i_clk);
		h_addr <= a;
		h_rd <= 1'b1;
		@(posedge i_clk);
		h_rd <= 1'b0;
		#1 d = h_rdata;
	endtask : host_rd

	// One device access through the master, polling busy under a bound
	task automatic dev(input logic [3:0] a, input logic [2:0] op, input logic [15:0] d,
		output logic [15:0] q);
		logic [15:0] s;
		int i;
		host_wr(tc_pkg::H_DATA, d);
		host_wr(tc_pkg::H_ADDR, {12'h000, a});
		host_wr(tc_pkg::H_CMD, {13'h0000, op});
		s = 16'h0001;
		for (i = 0; i < 20 && s[0] !== 1'b0; i++) begin
			host_rd(tc_pkg::H_STAT, s);
			seen |= s[2:0];
		end
		if (s[0] !== 1'b0) check(s, 16'h0000);
		host_rd(tc_pkg::H_DATA, q);
		if (op[2] == 1'b0) q[15:8] = 8'h00;
	endtask : dev

	task automatic wr(input logic [3:0] a, input logic wide, input logic [15:0] d);
		logic [15:0] q;
		dev(a, {wide, 2'b01}, d, q);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic wide, output logic [15:0] q);
		dev(a, {wide, 2'b11}, 16'h0000, q);
	endtask : rd

	task automatic pin(input logic lvl);
		@(posedge i_clk) cap_pin <= lvl;
		repeat (12) @(posedge i_clk);
	endtask : pin

	// Cycles from a rising pin edge to the capture request
	task automatic latency(output int n);
		@(posedge i_clk) cap_pin <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			#1 n++;
		end while (bus.cap_irq !== 1'b1 && n < 40);
		pin(1'b0);
	endtask : latency

	task automatic t_reset;
		check({15'h0000, zero_flag}, 16'h0001);
		check({15'h0000, top_flag}, 16'h0000);
		rd(tc_pkg::CNT_LO, 1'b1, v);
		check(v, tc_pkg::CNT_RST);
		rd(4'hF, 1'b0, v);
		check(v, 16'h0000);
		rd(tc_pkg::CTRL_B, 1'b0, v);
		check(v, 16'h0000);
	endtask : t_reset

	task automatic t_counter;
		wr(tc_pkg::CNT_LO, 1'b1, 16'h1234);
		rd(tc_pkg::CNT_LO, 1'b1, v);
		check(v, 16'h1234);
		repeat (20) @(posedge i_clk);
		rd(tc_pkg::CNT_LO, 1'b1, v);
		check(v, 16'h1234);
		check({15'h0000, zero_flag}, 16'h0000);
	endtask : t_counter

	task automatic t_wrap;
		wr(tc_pkg::MASK, 1'b0, 16'h0001);
		wr(tc_pkg::CNT_LO, 1'b1, 16'hFFF0);
		seen = 3'h0;
		wr(tc_pkg::CTRL_B, 1'b0, {13'h0000, tc_pkg::CS_DIV1});
		repeat (30) @(posedge i_clk);
		wr(tc_pkg::CTRL_B, 1'b0, 16'h0000);
		rd(tc_pkg::CNT_LO, 1'b1, v);
		check({15'h0000, v > 16'h0010 && v < 16'h0200}, 16'h0001);
		rd(tc_pkg::CNT_LO, 1'b1, c);
		check(c, v);
		check({15'h0000, top_seen}, 16'h0001);
		check({15'h0000, seen[1]}, 16'h0001);
		wr(tc_pkg::MASK, 1'b0, 16'h0000);
	endtask : t_wrap

	// Three falling edges on the external tick pin advance the counter by three
	task automatic t_ext_clock;
		wr(tc_pkg::CNT_LO, 1'b1, 16'h0010);
		wr(tc_pkg::CTRL_B, 1'b0, {13'h0000, tc_pkg::CS_EXT_FALL});
		repeat (3) begin
			@(posedge i_clk) ext_pin <= 1'b1;
			repeat (6) @(posedge i_clk);
			ext_pin <= 1'b0;
			repeat (6) @(posedge i_clk);
		end
		wr(tc_pkg::CTRL_B, 1'b0, 16'h0000);
		rd(tc_pkg::CNT_LO, 1'b1, v);
		check(v, 16'h0013);
	endtask : t_ext_clock

	task automatic t_capture;
		wr(tc_pkg::CTRL_B, 1'b0, 16'h0040);
		wr(tc_pkg::CNT_LO, 1'b1, 16'hABCD);
		pin(1'b1);
		rd(tc_pkg::FLAGS, 1'b0, v);
		check(v, 16'h0020);
		rd(tc_pkg::CAP_LO, 1'b1, v);
		check(v, 16'hABCD);
		wr(tc_pkg::CNT_LO, 1'b1, 16'h1111);
		pin(1'b0);
		rd(tc_pkg::CAP_LO, 1'b1, v);
		check(v, 16'hABCD);
		wr(tc_pkg::CTRL_B, 1'b0, 16'h0000);
		wr(tc_pkg::FLAGS, 1'b0, 16'h0020);
		rd(tc_pkg::FLAGS, 1'b0, v);
		check(v, 16'h0000);
		pin(1'b1);
		wr(tc_pkg::CNT_LO, 1'b1, 16'h2222);
		pin(1'b0);
		rd(tc_pkg::CAP_LO, 1'b1, v);
		check(v, 16'h2222);
	endtask : t_capture

	task automatic t_comparator;
		wr(tc_pkg::CTRL_B, 1'b0, 16'h0040);
		wr(tc_pkg::CMP_CTRL, 1'b0, 16'h0004);
		wr(tc_pkg::FLAGS, 1'b0, 16'h0020);
		wr(tc_pkg::CNT_LO, 1'b1, 16'h3333);
		@(posedge i_clk) comp_out <= 1'b1;
		repeat (12) @(posedge i_clk);
		wr(tc_pkg::CNT_LO, 1'b1, 16'h4444);
		pin(1'b1);
		rd(tc_pkg::CAP_LO, 1'b1, v);
		check(v, 16'h3333);
		wr(tc_pkg::CMP_CTRL, 1'b0, 16'h0000);
		pin(1'b0);
	endtask : t_comparator

	task automatic t_filter;
		wr(tc_pkg::MASK, 1'b0, 16'h0020);
		wr(tc_pkg::FLAGS, 1'b0, 16'h0020);
		latency(n0);
		wr(tc_pkg::CTRL_B, 1'b0, 16'h00C0);
		latency(n1);
		check({15'h0000, n0 < 9}, 16'h0001);
		check(16'(n1 - n0), 16'(tc_pkg::FILT_LEN));
		@(posedge i_clk) cap_pin <= 1'b1;
		repeat (2) @(posedge i_clk);
		cap_pin <= 1'b0;
		n0 = 0;
		repeat (15) begin
			@(posedge i_clk);
			#1 if (bus.cap_irq === 1'b1) n0++;
		end
		check(16'(n0), 16'h0000);
		wr(tc_pkg::MASK, 1'b0, 16'h0000);
	endtask : t_filter

	task automatic t_capwrite;
		wr(tc_pkg::CTRL_B, 1'b0, 16'h0000);
		rd(tc_pkg::CAP_LO, 1'b1, c);
		wr(tc_pkg::CAP_LO, 1'b1, 16'h0345);
		rd(tc_pkg::CAP_LO, 1'b1, v);
		check(v, c);
		wr(tc_pkg::CTRL_B, 1'b0, 16'h0058);
		wr(tc_pkg::CAP_LO, 1'b1, 16'h0345);
		rd(tc_pkg::CAP_LO, 1'b1, v);
		check(v, 16'h0345);
		wr(tc_pkg::CNT_LO, 1'b1, 16'h0100);
		pin(1'b1);
		rd(tc_pkg::CAP_LO, 1'b1, v);
		check(v, 16'h0345);
		wr(tc_pkg::CNT_LO, 1'b1, 16'h0345);
		check({15'h0000, top_flag}, 16'h0001);
		pin(1'b0);
		wr(tc_pkg::CTRL_A, 1'b0, 16'h0002);
		wr(tc_pkg::CTRL_B, 1'b0, 16'h0008);
		wr(tc_pkg::CNT_LO, 1'b1, tc_pkg::TOP_9);
		check({15'h0000, top_flag}, 16'h0001);
	endtask : t_capwrite

	task automatic tally_and_finish;
		if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish

	// Main sequence
	initial begin
		repeat (10) @(posedge i_clk);
		i_reset_n <= 1'b1;
		t_reset();
		t_counter();
		t_wrap();
		t_ext_clock();
		t_capture();
		t_comparator();
		t_filter();
		t_capwrite();
		tally_and_finish();
	end

	// Watchdog, far beyond the expected run
	initial begin
		#800000;
		miscompares++;
		tally_and_finish();
	end
endmodule : tb
